// ---- pkg/rpms_pkg.sv ----
`default_nettype none
package rpms_pkg;
    localparam logic [7:0] ADDR_PWR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_REG_SETUP = 8'h0b;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] PWR_CTRL_RESET = 8'h01;
    localparam logic [7:0] REG_SETUP_RESET = 8'h87;
    localparam int BIT_STANDBY = 7;
    localparam int BIT_RF_ALL = 5;
    localparam int BIT_HALF_PWR = 4;
    localparam int BIT_RX_ONLY = 1;
    localparam int BIT_SUPPLY_5V = 0;
    localparam int CLK_MHZ = 100;
    localparam int CONFIRM_US = 100;
    localparam int CONFIRM_CYC = CONFIRM_US * CLK_MHZ;
    localparam int STANDBY_REC_US = 100;
    localparam int STANDBY_REC_CYC = STANDBY_REC_US * CLK_MHZ;
    localparam int MODE1_REC_US = 25;
    localparam int MODE1_REC_CYC = MODE1_REC_US * CLK_MHZ;
    localparam int SETTLE_US = 50;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int AUX_DIV = 1666;
    localparam int CNT_W = 16;
    typedef enum logic [5:0] {
        RPMS_OFF = 6'h01,
        RPMS_SLEEP = 6'h02,
        RPMS_START = 6'h04,
        RPMS_CONFIRM = 6'h08,
        RPMS_ACTIVE = 6'h10,
        RPMS_RECOVER = 6'h20
    } rpms_state_t;
endpackage : rpms_pkg
`default_nettype wire

// ---- pkg/rpms_cnt_if.sv ----
`default_nettype none
interface rpms_cnt_if;
    import rpms_pkg::*;
    logic load;
    logic [CNT_W-1:0] value;
    logic done;
    modport ctl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface : rpms_cnt_if
`default_nettype wire

// ---- rtl/rpms_timer.sv ----
`default_nettype none
module rpms_timer
    import rpms_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic reset_n, // async reset, active low
    rpms_cnt_if.tmr cnt // load/expiry handshake
);
    logic [CNT_W-1:0] count_reg;
    logic run_reg;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
            run_reg <= 1'b0;
        end else if (cnt.load) begin
            count_reg <= cnt.value;
            run_reg <= 1'b1;
        end else if (run_reg && count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end else begin
            run_reg <= 1'b0;
        end
    end
    // done is a one-cycle pulse when the count reaches zero
    assign cnt.done = run_reg && (count_reg == '0) && !cnt.load;
endmodule : rpms_timer
`default_nettype wire

// ---- rtl/rpms_sequencer.sv ----
`default_nettype none
// Notes on behaviour
// - both pins low: everything powered off
// - wake only: logic rail, aux clock
// - wake rising edge starts supplies from off
// - main high or wake edge starts regulators
// - clock switch after settle; then accept writes
// - unconfirmed wake start returns off after 100us
// - main high: register bits choose mode
// - bit 7 standby, recovery 100us
// - bits 5,1 clear: mode 1, 25us recovery
// - bit 1 only: receiver only
// - bit 5: transmitter and receiver on
// - bit 0 selects 5 V supply, default
module rpms_sequencer
    import rpms_pkg::*;
(
    input wire logic core_clk, // 100 MHz clock
    input wire logic reset_n, // async reset, active low
    input wire logic main_enable_pin, // main enable from controller
    input wire logic wake_enable_pin, // wake enable pin
    input wire logic osc_stable, // oscillator and supplies settled
    input wire logic [7:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr_stb, // write strobe
    input wire logic rd_stb, // read strobe
    output logic [7:0] rdata, // read data, cycle after rd_stb
    output logic logic_supply_rail, // logic supply on
    output logic regulators_on, // main regulators and oscillator on
    output logic aux_clk_en, // mcu_clock_out carries 60 kHz
    output logic hf_clk_en, // crystal clock enabled; mcu_clock_out held low
    output logic mcu_clock_out, // clock to controller (aux phase)
    output logic tx_enable, // transmitter on
    output logic rx_enable, // receiver on
    output logic tx_half_power, // half transmit power
    output logic supply_5v_sel, // 5-V input supply configuration
    output logic full_ready // full operation reached
);
    logic main_m_reg, main_s_reg, wake_m_reg, wake_s_reg, wake_d_reg, osc_m_reg, osc_s_reg;
    logic [7:0] pwr_ctrl_reg, reg_setup_reg;
    rpms_state_t state_reg, state_next;
    logic wake_start_reg;
    logic [15:0] aux_cnt_reg;
    logic aux_phase_reg;
    logic wake_rise;
    logic regs_open;
    logic [CNT_W-1:0] rec_value;
    rpms_cnt_if cnt_bus ();

    rpms_timer u_timer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .cnt(cnt_bus.tmr)
    );

    // pins come from another domain
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_m_reg <= 1'b0;
            main_s_reg <= 1'b0;
            wake_m_reg <= 1'b0;
            wake_s_reg <= 1'b0;
            wake_d_reg <= 1'b0;
            osc_m_reg <= 1'b0;
            osc_s_reg <= 1'b0;
        end else begin
            main_m_reg <= main_enable_pin;
            main_s_reg <= main_m_reg;
            wake_m_reg <= wake_enable_pin;
            wake_s_reg <= wake_m_reg;
            wake_d_reg <= wake_s_reg;
            osc_m_reg <= osc_stable;
            osc_s_reg <= osc_m_reg;
        end
    end

    assign wake_rise = wake_s_reg && !wake_d_reg;
    assign regs_open = (state_reg == RPMS_ACTIVE) || (state_reg == RPMS_RECOVER)
        || (state_reg == RPMS_CONFIRM);

    // recovery time depends on the mode being left
    always_comb begin
        if (pwr_ctrl_reg[BIT_STANDBY]) begin
            rec_value = CNT_W'(STANDBY_REC_CYC);
        end else begin
            rec_value = CNT_W'(MODE1_REC_CYC);
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_bus.load = 1'b0;
        cnt_bus.value = '0;
        case (state_reg)
            RPMS_OFF: begin
                if (main_s_reg || wake_rise) begin
                    state_next = RPMS_START;
                end else if (wake_s_reg) begin
                    state_next = RPMS_SLEEP;
                end
            end
            RPMS_SLEEP: begin
                if (main_s_reg) begin
                    state_next = RPMS_START;
                end else if (!wake_s_reg) begin
                    state_next = RPMS_OFF;
                end
            end
            RPMS_START: begin
                if (!main_s_reg && !wake_start_reg && !wake_s_reg) begin
                    state_next = RPMS_OFF;
                end else if (osc_s_reg) begin
                    if (wake_start_reg && !main_s_reg) begin
                        state_next = RPMS_CONFIRM;
                        cnt_bus.load = 1'b1;
                        cnt_bus.value = CNT_W'(CONFIRM_CYC);
                    end else begin
                        state_next = RPMS_RECOVER;
                        cnt_bus.load = 1'b1;
                        cnt_bus.value = rec_value;
                    end
                end
            end
            RPMS_CONFIRM: begin
                if (main_s_reg) begin
                    state_next = RPMS_ACTIVE;
                end else if (cnt_bus.done) begin
                    state_next = RPMS_OFF;
                end
            end
            RPMS_RECOVER: begin
                if (!main_s_reg) begin
                    state_next = wake_s_reg ? RPMS_SLEEP : RPMS_OFF;
                end else if (cnt_bus.done) begin
                    state_next = RPMS_ACTIVE;
                end
            end
            RPMS_ACTIVE: begin
                if (!main_s_reg) begin
                    state_next = wake_s_reg ? RPMS_SLEEP : RPMS_OFF;
                end else if (wr_stb && addr == ADDR_PWR_CTRL
                    && pwr_ctrl_reg[BIT_STANDBY] && !wdata[BIT_STANDBY]) begin
                    state_next = RPMS_RECOVER;
                    cnt_bus.load = 1'b1;
                    cnt_bus.value = CNT_W'(STANDBY_REC_CYC);
                end
            end
            default: state_next = RPMS_OFF;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= RPMS_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // remembers whether this start-up came from the wake edge
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_start_reg <= 1'b0;
        end else if (state_reg != RPMS_START && state_next == RPMS_START) begin
            wake_start_reg <= !main_s_reg;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_ctrl_reg <= PWR_CTRL_RESET;
            reg_setup_reg <= REG_SETUP_RESET;
        end else if (wr_stb && regs_open) begin
            if (addr == ADDR_PWR_CTRL) begin
                pwr_ctrl_reg <= wdata;
            end else if (addr == ADDR_REG_SETUP) begin
                reg_setup_reg <= wdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else if (rd_stb) begin
            if (addr == ADDR_PWR_CTRL) begin
                rdata <= pwr_ctrl_reg;
            end else if (addr == ADDR_REG_SETUP) begin
                rdata <= reg_setup_reg;
            end else if (addr == ADDR_STATUS) begin
                rdata <= {2'b00, state_reg};
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // 60 kHz aux clock from a divider on the core clock
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aux_cnt_reg <= 16'h0000;
            aux_phase_reg <= 1'b0;
        end else if (aux_cnt_reg == 16'(AUX_DIV / 2 - 1)) begin
            aux_cnt_reg <= 16'h0000;
            aux_phase_reg <= !aux_phase_reg;
        end else begin
            aux_cnt_reg <= aux_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            logic_supply_rail <= 1'b0;
            regulators_on <= 1'b0;
            aux_clk_en <= 1'b0;
            hf_clk_en <= 1'b0;
            mcu_clock_out <= 1'b0;
            full_ready <= 1'b0;
        end else begin
            logic_supply_rail <= state_next != RPMS_OFF;
            regulators_on <= state_next inside {RPMS_START, RPMS_CONFIRM,
                RPMS_ACTIVE, RPMS_RECOVER};
            aux_clk_en <= state_next inside {RPMS_SLEEP, RPMS_START};
            hf_clk_en <= state_next inside {RPMS_CONFIRM, RPMS_ACTIVE,
                RPMS_RECOVER};
            mcu_clock_out <= (state_next inside {RPMS_SLEEP, RPMS_START}) && aux_phase_reg;
            full_ready <= state_next == RPMS_ACTIVE && !pwr_ctrl_reg[BIT_STANDBY];
        end
    end

    // mode decode from register bits only while main is high
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_enable <= 1'b0;
            rx_enable <= 1'b0;
            tx_half_power <= 1'b0;
            supply_5v_sel <= 1'b1;
        end else begin
            supply_5v_sel <= pwr_ctrl_reg[BIT_SUPPLY_5V];
            if (state_next == RPMS_ACTIVE && !pwr_ctrl_reg[BIT_STANDBY]) begin
                tx_enable <= pwr_ctrl_reg[BIT_RF_ALL];
                rx_enable <= pwr_ctrl_reg[BIT_RF_ALL] || pwr_ctrl_reg[BIT_RX_ONLY];
                tx_half_power <= pwr_ctrl_reg[BIT_RF_ALL] && pwr_ctrl_reg[BIT_HALF_PWR];
            end else begin
                tx_enable <= 1'b0;
                rx_enable <= 1'b0;
                tx_half_power <= 1'b0;
            end
        end
    end

    // cycles spent waiting for the wake confirmation; a counter keeps the long
    // timeout check cheap, a delay range of this length would not be
    logic [CNT_W-1:0] confirm_age_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            confirm_age_reg <= '0;
        end else if (state_reg == RPMS_CONFIRM) begin
            confirm_age_reg <= confirm_age_reg + 1'b1;
        end else begin
            confirm_age_reg <= '0;
        end
    end

    sequence s_wake_settled;
        state_reg == RPMS_START && osc_s_reg && wake_start_reg && !main_s_reg;
    endsequence
    sequence s_main_settled;
        state_reg == RPMS_START && osc_s_reg && main_s_reg;
    endsequence
    sequence s_confirm_entered;
        state_reg == RPMS_CONFIRM && hf_clk_en && !aux_clk_en;
    endsequence
    sequence s_recover_entered;
        state_reg == RPMS_RECOVER && hf_clk_en && !aux_clk_en;
    endsequence

    chk_off_no_rf: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_reg == RPMS_OFF |=> !tx_enable && !hf_clk_en)
        else $error("rf or hf clock on while off");
    chk_confirm_timeout: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_reg == RPMS_CONFIRM |-> confirm_age_reg <= CNT_W'(CONFIRM_CYC))
        else $error("wake start never timed out");
    chk_half_power: assert property (@(posedge core_clk) disable iff (!reset_n)
        tx_half_power |-> tx_enable)
        else $error("half power without transmitter");
    chk_wake_confirm: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_wake_settled |=> s_confirm_entered)
        else $error("wake start did not switch clock into confirm");
    chk_main_recover: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_main_settled |=> s_recover_entered)
        else $error("main start did not switch clock into recovery");
    chk_closed_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_stb && !regs_open |=> $stable(pwr_ctrl_reg) && $stable(reg_setup_reg))
        else $error("register written before clock switch");
    chk_sleep_outputs: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_reg == RPMS_SLEEP |-> logic_supply_rail && aux_clk_en && !hf_clk_en
        && !regulators_on)
        else $error("sleep outputs wrong");
    chk_rf_only_active: assert property (@(posedge core_clk) disable iff (!reset_n)
        tx_enable || rx_enable |-> state_reg == RPMS_ACTIVE)
        else $error("rf section on outside active state");
endmodule : rpms_sequencer
`default_nettype wire

// ---- sim/rpms_mcu_model.sv ----
`default_nettype none
// controller and crystal seen from the reader: pins change one at a time, spaced apart
module rpms_mcu_model #(
    parameter int SETTLE = 200,
    parameter int GAP = 20
) (
    input wire logic core_clk, // reader clock
    input wire logic regulators_on, // supplies started
    output logic main_enable_pin, // main enable
    output logic wake_enable_pin, // wake enable
    output logic osc_stable // supplies and oscillator settled
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial begin
        main_enable_pin = 1'h0;
        wake_enable_pin = 1'h0;
    end
    // settling restarts whenever the supplies drop
    always @(posedge core_clk) begin
        cnt <= (regulators_on !== 1'h1) ? 0 : ((cnt < SETTLE) ? cnt + 1 : cnt);
    end
    assign osc_stable = (cnt >= SETTLE);
    // gap scaled down from milliseconds to keep the run short
    task automatic set_pin(input bit main_sel, input logic v);
        repeat (GAP) @(posedge core_clk);
        if (main_sel) begin
            main_enable_pin <= v;
        end else begin
            wake_enable_pin <= v;
        end
    endtask : set_pin
endmodule : rpms_mcu_model
`default_nettype wire

// ---- sim/tb_reader_power_mode_sequencer.sv ----
`default_nettype none
module tb_reader_power_mode_sequencer import rpms_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0;
    logic reset_n = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'h0;
    logic rd_stb = 1'h0;
    logic [7:0] rdata;
    logic rail, regs, aux, hf, mclk, tx, rx, half, v5, ready, main_pin, wake_pin, osc;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int tog = 0;
    logic [7:0] mv [5] = '{8'h01, 8'h03, 8'h31, 8'h20, 8'h21};
    logic [7:0] ev [5] = '{8'hd1, 8'hd5, 8'hdf, 8'hdd, 8'hdd};
    wire logic [7:0] outs = {rail, regs, aux, hf, tx, rx, half, ready};

    rpms_sequencer dut (.core_clk(core_clk), .reset_n(reset_n), .main_enable_pin(main_pin),
        .wake_enable_pin(wake_pin), .osc_stable(osc), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .logic_supply_rail(rail),
        .regulators_on(regs), .aux_clk_en(aux), .hf_clk_en(hf), .mcu_clock_out(mclk),
        .tx_enable(tx), .rx_enable(rx), .tx_half_power(half), .supply_5v_sel(v5),
        .full_ready(ready));
    rpms_mcu_model mcu (.core_clk(core_clk), .regulators_on(regs), .main_enable_pin(main_pin),
        .wake_enable_pin(wake_pin), .osc_stable(osc));

    always #5 core_clk = ~core_clk;
    always @(mclk) tog++;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
        end
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'h1;
        @(posedge core_clk);
        wr_stb <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge core_clk);
        rd_stb <= 1'h0;
        #1;
        check(rdata, exp);
    endtask : rd
    // bounded wait on the clock switch or on full operation
    task automatic wait_on(input int n, input bit pick_ready);
        int k;
        k = 0;
        while (k < n && (pick_ready ? ready : hf) !== 1'h1) begin
            cyc(1);
            k++;
        end
    endtask : wait_on

    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'h1;
        cyc(2);
        check(outs, 8'h00);
        check({7'h0, v5}, 8'h01);
        rd(ADDR_PWR_CTRL, PWR_CTRL_RESET);
        rd(ADDR_REG_SETUP, REG_SETUP_RESET);
        rd(8'h05, 8'h00);
        rd(ADDR_STATUS, {2'b00, RPMS_OFF});
        wr(ADDR_PWR_CTRL, 8'h21);
        rd(ADDR_PWR_CTRL, PWR_CTRL_RESET);
        tog = 0;
        cyc(2000);
        check(tog[7:0], 8'h00);
        mcu.set_pin(0, 1'h1);
        cyc(4);
        check({6'h0, regs, aux}, 8'h03);
        wr(ADDR_PWR_CTRL, 8'h21);
        rd(ADDR_PWR_CTRL, PWR_CTRL_RESET);
        wait_on(400, 1'b0);
        check({6'h0, hf, aux}, 8'h02);
        wr(ADDR_PWR_CTRL, 8'h03);
        rd(ADDR_PWR_CTRL, 8'h03);
        rd(ADDR_STATUS, {2'b00, RPMS_CONFIRM});
        cyc(9890);
        check({7'h0, regs}, 8'h01);
        cyc(310);
        check({6'h0, regs, hf}, 8'h00);
        mcu.set_pin(0, 1'h0);
        cyc(4);
        check(outs, 8'h00);
        mcu.set_pin(1, 1'h1);
        wait_on(400, 1'b0);
        wr(ADDR_PWR_CTRL, 8'h01);
        wait_on(2600, 1'b1);
        check({7'h0, ready}, 8'h01);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_PWR_CTRL, mv[i]);
            cyc(3);
            check(outs, ev[i]);
            check({7'h0, v5}, {7'h0, mv[i][0]});
            rd(ADDR_PWR_CTRL, mv[i]);
        end
        wr(ADDR_REG_SETUP, 8'h07);
        rd(ADDR_REG_SETUP, 8'h07);
        rd(ADDR_STATUS, {2'b00, RPMS_ACTIVE});
        wr(ADDR_PWR_CTRL, 8'h81);
        cyc(3);
        check({5'h0, tx, rx, hf}, 8'h01);
        wr(ADDR_PWR_CTRL, 8'h21);
        wait_on(10100, 1'b1);
        cyc(3);
        check(outs, 8'hdd);
        mcu.set_pin(0, 1'h1);
        mcu.set_pin(1, 1'h0);
        cyc(6);
        check(outs, 8'ha0);
        tog = 0;
        cyc(2000);
        check({7'h0, tog >= 2}, 8'h01);
        mcu.set_pin(0, 1'h0);
        cyc(4);
        check(outs, 8'h00);
        mcu.set_pin(0, 1'h1);
        wait_on(400, 1'b0);
        mcu.set_pin(1, 1'h1);
        cyc(10200);
        check({6'h0, regs, hf}, 8'h03);
        give_verdict();
    end
endmodule : tb_reader_power_mode_sequencer
`default_nettype wire
